// *** core/dmh_pkg.sv ***
// constants and types for the dual multiply-accumulate datapath
package dmh_pkg;
    localparam int DATA_W = 16;
    localparam int EXT_W = 17;
    localparam int PROD_W = 32;
    localparam int ACC_W = 40;
    localparam int SHIFT_N = 16;
    localparam int NUM_ACC = 4;
    localparam int ADDR_W = 16;

    localparam logic [7:0] OPC_BYTE0 = 8'h93;
    localparam logic [1:0] VAR_ACX_SHIFT = 2'h0;
    localparam logic [1:0] VAR_BOTH_SHIFT = 2'h3;
    // field positions: variant/cmode in slot 1 low byte, the rest in the slot 2 byte
    localparam int VAR_LSB = 2;
    localparam int CMODE_LSB = 0;
    localparam int UNS_DATA_BIT = 7;
    localparam int UNS_COEF_BIT = 6;
    localparam int ACX_LSB = 4;
    localparam int ACY_LSB = 2;
    localparam int G40_BIT = 1;
    localparam int RND_BIT = 0;

    localparam logic [1:0] CM_NONE = 2'h0;
    localparam logic [1:0] CM_INC = 2'h1;
    localparam logic [1:0] CM_DEC = 2'h2;

    localparam logic [ADDR_W-1:0] CDP_STEP = 16'h0002;
    localparam logic [ADDR_W-1:0] PARTNER_STEP = 16'h0001;
    localparam logic [ADDR_W-1:0] CDP_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] MMR_TOP = 16'h0060;

    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [ACC_W:0] RND_HALF = 41'h000_0000_8000;
    localparam logic [15:0] RND_TIE = 16'h8000;
    localparam logic [ACC_W-1:0] SAT40_POS = 40'h7f_ffff_ffff;
    localparam logic [ACC_W-1:0] SAT40_NEG = 40'h80_0000_0000;
    localparam logic [ACC_W-1:0] SAT32_POS = 40'h00_7fff_ffff;
    localparam logic [ACC_W-1:0] SAT32_NEG = 40'hff_8000_0000;
    localparam logic [PROD_W-1:0] PROD_SAT = 32'h7fff_ffff;
    localparam logic [EXT_W-1:0] MIN17 = 17'h1_8000;

    typedef struct packed {
        logic sign_extension_mode_bit;
        logic fractional_mode_bit;
        logic multiply_saturation_mode_bit;
        logic wide_overflow_mode_bit;
        logic rounding_method_bit;
        logic accumulator_saturation_bit;
    } dmh_mode_t;

    typedef struct packed {
        logic both_shift;
        logic data_uns;
        logic coef_uns;
        logic [1:0] acx_sel;
        logic [1:0] acy_sel;
        logic force40;
        logic rnd;
        logic [1:0] cmode;
    } dmh_fields_t;

    typedef enum logic {ST_IDLE = 1'b0, ST_RPT = 1'b1} dmh_state_t;
endpackage

// *** core/dmh_mac_unit.sv ***
// one multiply-accumulate unit: extend, multiply, shift, add, round, saturate
`timescale 1ns/1ps
module dmh_mac_unit import dmh_pkg::*; (
    input wire logic [DATA_W-1:0] data, // data operand half
    input wire logic [DATA_W-1:0] coef, // coefficient half
    input wire logic data_uns, // zero-extend data
    input wire logic coef_uns, // zero-extend coefficient
    input wire dmh_mode_t mode, // mode bits
    input wire logic wide, // effective 40-bit overflow mode
    input wire logic rnd, // rounding option
    input wire logic shift_src, // shift source accumulator right
    input wire logic [ACC_W-1:0] acc_in, // source accumulator
    output logic [ACC_W-1:0] acc_out, // result
    output logic ovf // accumulator overflow
);
    logic signed [EXT_W-1:0] data_ext;
    logic signed [EXT_W-1:0] coef_ext;
    logic signed [2*EXT_W-1:0] prod_full;
    logic [PROD_W-1:0] prod32;
    logic [ACC_W-1:0] prod40;
    logic [ACC_W-1:0] src;
    logic [ACC_W:0] sum;
    logic [ACC_W:0] rsum;

    always_comb begin
        data_ext = (data_uns || !mode.sign_extension_mode_bit) ? {1'b0, data} : {data[DATA_W-1], data};
        coef_ext = (coef_uns || !mode.sign_extension_mode_bit) ? {1'b0, coef} : {coef[DATA_W-1], coef};
    end

    assign prod_full = data_ext * coef_ext;

    always_comb begin
        // with both operands sign-extended, only min*min can overflow the doubled product
        if (mode.multiply_saturation_mode_bit && mode.fractional_mode_bit && data_ext == MIN17
            && coef_ext == MIN17) begin
            prod32 = PROD_SAT;
        end else if (mode.fractional_mode_bit) begin
            prod32 = {prod_full[PROD_W-2:0], 1'b0};
        end else begin
            prod32 = prod_full[PROD_W-1:0];
        end
        prod40 = {{(ACC_W-PROD_W){prod32[PROD_W-1]}}, prod32};
        src = shift_src ? {{SHIFT_N{acc_in[ACC_W-1]}}, acc_in[ACC_W-1:SHIFT_N]} : acc_in;
        sum = {src[ACC_W-1], src} + {prod40[ACC_W-1], prod40};
        rsum = sum;
        if (rnd) begin
            rsum = sum + RND_HALF;
            // unbiased method: an exact tie rounds to even
            if (mode.rounding_method_bit && sum[15:0] == RND_TIE) begin
                rsum[16] = 1'b0;
            end
            rsum[15:0] = 16'h0000;
        end
        if (wide) begin
            ovf = rsum[ACC_W] != rsum[ACC_W-1];
        end else begin
            ovf = !((&rsum[ACC_W:PROD_W-1]) || !(|rsum[ACC_W:PROD_W-1]));
        end
        if (ovf && mode.accumulator_saturation_bit) begin
            if (wide) begin
                acc_out = rsum[ACC_W] ? SAT40_NEG : SAT40_POS;
            end else begin
                acc_out = rsum[ACC_W] ? SAT32_NEG : SAT32_POS;
            end
        end else begin
            acc_out = rsum[ACC_W-1:0];
        end
    end
endmodule // dmh_mac_unit

// *** core/dmh_dual_mac.sv ***
// dual multiply-accumulate datapath with decode, coefficient pointer and repeat
`timescale 1ns/1ps
module dmh_dual_mac import dmh_pkg::*; #(
    parameter int RPT_W = 8
) (
    input wire logic clk, // clock
    input wire logic rst, // synchronous reset
    input wire logic issue_valid, // instruction offered
    output logic issue_ready, // block can take an instruction
    input wire logic [31:0] slot1_word, // first four bytes, opcode byte on top
    input wire logic [7:0] slot2_byte, // least significant byte from slot 2
    input wire logic pair_active, // another instruction offered in parallel
    input wire logic [RPT_W-1:0] rpt_count, // extra repetitions
    input wire logic [ADDR_W-1:0] xmem_addr, // lower data operand address
    input wire logic [ADDR_W-1:0] ymem_addr, // upper data operand address
    input wire logic [DATA_W-1:0] xmem_lo_data, // lower data operand
    input wire logic [DATA_W-1:0] ymem_hi_data, // upper data operand
    output logic coef_rd_en, // coefficient read this cycle
    output logic [ADDR_W-1:0] coef_hi_addr, // upper coefficient address
    output logic [ADDR_W-1:0] coef_lo_addr, // lower coefficient address
    input wire logic [DATA_W-1:0] second_coefficient_data_bus, // upper coefficient
    input wire logic [DATA_W-1:0] first_coefficient_data_bus, // lower coefficient
    input wire dmh_mode_t mode, // status mode bits
    input wire logic cptr_load, // load coefficient pointer
    input wire logic [ADDR_W-1:0] cptr_load_value, // pointer load value
    input wire logic acc_wr_en, // software accumulator write
    input wire logic [1:0] acc_wr_sel, // accumulator to write
    input wire logic [ACC_W-1:0] acc_wr_data, // write data
    input wire logic [NUM_ACC-1:0] ovf_clear, // clear overflow flags
    output logic [NUM_ACC-1:0][ACC_W-1:0] acc_q, // accumulators
    output logic [NUM_ACC-1:0] ovf_flags, // accumulator overflow flags
    output logic [ADDR_W-1:0] coefficient_pointer, // pointer value
    output logic busy, // repeat in progress
    output logic exec_done, // one execution completed
    output logic decode_reject, // opcode not recognised
    output logic pair_reject, // refused for parallel pairing
    output logic mmr_reject // upper operand hit mapped registers
);
    generate
        if (RPT_W < 1 || RPT_W > 16) begin : g_bad_rpt
            $error("RPT_W must be 1 to 16");
        end
    endgenerate

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    dmh_state_t state_reg;
    logic [RPT_W-1:0] cnt_reg;
    dmh_fields_t fld_reg;
    dmh_fields_t dec;
    dmh_fields_t fld;
    logic [NUM_ACC-1:0][ACC_W-1:0] acc_reg;
    logic [NUM_ACC-1:0] ovf_reg;
    logic [ADDR_W-1:0] cdp_reg;
    logic opc_ok;
    logic ymem_in_mmr;
    logic take;
    logic start;
    logic rep;
    logic exec;
    logic wide;
    logic [ACC_W-1:0] hi_res;
    logic [ACC_W-1:0] lo_res;
    logic hi_ovf;
    logic lo_ovf;
    logic exec_reg;
    logic dec_rej_reg;
    logic pair_rej_reg;
    logic mmr_rej_reg;

    // decode of the five-byte form
    always_comb begin
        opc_ok = slot1_word[31:24] == OPC_BYTE0
            && (slot1_word[VAR_LSB+1:VAR_LSB] == VAR_ACX_SHIFT
            || slot1_word[VAR_LSB+1:VAR_LSB] == VAR_BOTH_SHIFT);
        dec.both_shift = slot1_word[VAR_LSB+1:VAR_LSB] == VAR_BOTH_SHIFT;
        dec.cmode = slot1_word[CMODE_LSB+1:CMODE_LSB];
        dec.data_uns = slot2_byte[UNS_DATA_BIT];
        dec.coef_uns = slot2_byte[UNS_COEF_BIT];
        dec.acx_sel = slot2_byte[ACX_LSB+1:ACX_LSB];
        dec.acy_sel = slot2_byte[ACY_LSB+1:ACY_LSB];
        dec.force40 = slot2_byte[G40_BIT];
        dec.rnd = slot2_byte[RND_BIT];
    end

    assign issue_ready = state_reg == ST_IDLE;
    assign ymem_in_mmr = ymem_addr < MMR_TOP;
    assign take = issue_valid && issue_ready;
    // the long form fills both slots, so a parallel partner is refused outright
    assign start = take && opc_ok && !pair_active && !ymem_in_mmr;
    assign rep = state_reg == ST_RPT;
    assign exec = start || (rep && !ymem_in_mmr);
    assign fld = rep ? fld_reg : dec;
    // local 40-bit option never touches the stored mode bit
    assign wide = mode.wide_overflow_mode_bit || fld.force40;

    // repeat sequencing: 1 + rpt_count executions, one per cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start && rpt_count != '0) begin
                        state_reg <= ST_RPT;
                        cnt_reg <= rpt_count;
                    end
                end
                ST_RPT: begin
                    cnt_reg <= cnt_reg - 1'b1;
                    if (cnt_reg == RPT_W'(1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fld_reg <= '0;
        end else if (start) begin
            fld_reg <= dec;
        end
    end

    // coefficient addressing: upper half at pointer, lower at its partner
    assign coef_hi_addr = cdp_reg;
    assign coef_lo_addr = cdp_reg[0] ? cdp_reg - PARTNER_STEP : cdp_reg + PARTNER_STEP;
    assign coef_rd_en = exec;

    always_ff @(posedge clk) begin
        if (rst) begin
            cdp_reg <= CDP_RST;
        end else if (exec) begin
            case (fld.cmode)
                CM_INC: cdp_reg <= cdp_reg + CDP_STEP;
                CM_DEC: cdp_reg <= cdp_reg - CDP_STEP;
                default: cdp_reg <= cdp_reg;
            endcase
        end else if (cptr_load) begin
            cdp_reg <= cptr_load_value;
        end
    end

    // both units read the old accumulators; results land at one edge
    dmh_mac_unit u_upper_multiplier_unit (
        .data(ymem_hi_data),
        .coef(second_coefficient_data_bus),
        .data_uns(fld.data_uns),
        .coef_uns(fld.coef_uns),
        .mode(mode),
        .wide(wide),
        .rnd(fld.rnd),
        .shift_src(fld.both_shift),
        .acc_in(acc_reg[fld.acy_sel]),
        .acc_out(hi_res),
        .ovf(hi_ovf)
    );

    dmh_mac_unit u_lower_multiplier_unit (
        .data(xmem_lo_data),
        .coef(first_coefficient_data_bus),
        .data_uns(fld.data_uns),
        .coef_uns(fld.coef_uns),
        .mode(mode),
        .wide(wide),
        .rnd(fld.rnd),
        .shift_src(1'b1),
        .acc_in(acc_reg[fld.acx_sel]),
        .acc_out(lo_res),
        .ovf(lo_ovf)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= {NUM_ACC{ACC_RST}};
        end else if (exec) begin
            acc_reg[fld.acx_sel] <= lo_res;
            // same accumulator named twice: the upper result is kept
            acc_reg[fld.acy_sel] <= hi_res;
        end else if (acc_wr_en) begin
            acc_reg[acc_wr_sel] <= acc_wr_data;
        end
    end

    // a fresh overflow beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_ACC; i++) begin
                if (exec && ((lo_ovf && fld.acx_sel == i[1:0]) || (hi_ovf && fld.acy_sel == i[1:0]))) begin
                    ovf_reg[i] <= 1'b1;
                end else if (ovf_clear[i]) begin
                    ovf_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            exec_reg <= 1'b0;
            dec_rej_reg <= 1'b0;
            pair_rej_reg <= 1'b0;
            mmr_rej_reg <= 1'b0;
        end else begin
            exec_reg <= exec;
            dec_rej_reg <= take && !opc_ok;
            pair_rej_reg <= take && opc_ok && pair_active;
            mmr_rej_reg <= (take && opc_ok && !pair_active && ymem_in_mmr) || (rep && ymem_in_mmr);
        end
    end

    assign acc_q = acc_reg;
    assign ovf_flags = ovf_reg;
    assign coefficient_pointer = cdp_reg;
    assign busy = rep;
    assign exec_done = exec_reg;
    assign decode_reject = dec_rej_reg;
    assign pair_reject = pair_rej_reg;
    assign mmr_reject = mmr_rej_reg;

    // helper copies for the checks below
    logic [1:0] acx_q;
    logic [1:0] acy_q;
    logic [ACC_W-1:0] hi_res_q;
    logic [ACC_W-1:0] lo_res_q;
    always_ff @(posedge clk) begin
        acx_q <= fld.acx_sel;
        acy_q <= fld.acy_sel;
        hi_res_q <= hi_res;
        lo_res_q <= lo_res;
    end

    a_pair_refused: assert property (@(posedge clk) disable iff (rst)
        (take && pair_active) |-> !exec ##1 (exec_done == 1'b0 && pair_reject == $past(opc_ok)))
        else $error("paired issue was executed");

    a_ymem_mmr_block: assert property (@(posedge clk) disable iff (rst)
        ymem_in_mmr |-> !exec && !coef_rd_en)
        else $error("upper operand reached mapped registers");

    a_both_written: assert property (@(posedge clk) disable iff (rst)
        (exec && fld.acx_sel != fld.acy_sel) |=> (acc_reg[acx_q] == lo_res_q && acc_reg[acy_q] == hi_res_q))
        else $error("accumulators not both written in one cycle");

    a_old_operands: assert property (@(posedge clk) disable iff (rst)
        exec |=> exec_done && acc_reg[acy_q] == hi_res_q && (acc_reg[acx_q] == lo_res_q || acx_q == acy_q))
        else $error("lower result not written at the same edge");

    a_ptr_step_two: assert property (@(posedge clk) disable iff (rst)
        (exec && fld.cmode == CM_INC) |=> cdp_reg == $past(cdp_reg) + CDP_STEP)
        else $error("pointer did not advance by two");

    a_partner_addr: assert property (@(posedge clk) disable iff (rst)
        coef_rd_en |-> (coef_lo_addr ^ coef_hi_addr) == PARTNER_STEP
        && coef_hi_addr == coefficient_pointer)
        else $error("coefficient partner address wrong");

    a_variant_decode: assert property (@(posedge clk) disable iff (rst)
        start |-> fld.both_shift == (slot1_word[VAR_LSB+1:VAR_LSB] == VAR_BOTH_SHIFT))
        else $error("variant field decoded wrongly");

    a_ovf_flag_set: assert property (@(posedge clk) disable iff (rst)
        (exec && lo_ovf) |=> ovf_flags[acx_q])
        else $error("overflow flag not set");

    a_local_wide: assert property (@(posedge clk) disable iff (rst)
        (exec && fld.force40) |-> wide)
        else $error("40-bit option not applied");

    a_repeat_len: assert property (@(posedge clk) disable iff (rst)
        (start && rpt_count == RPT_W'(2)) |=> busy ##1 busy ##1 !busy && issue_ready)
        else $error("repeat length wrong");

    a_upper_unshifted: assert property (@(posedge clk) disable iff (rst)
        (exec && !fld.both_shift && !fld.rnd && !hi_ovf && ymem_hi_data == 16'h0000)
        |-> hi_res == acc_reg[fld.acy_sel])
        else $error("upper accumulator shifted in first variant");

    a_lower_shift_sign: assert property (@(posedge clk) disable iff (rst)
        (exec && !fld.rnd && xmem_lo_data == 16'h0000)
        |-> lo_res == {{SHIFT_N{acc_reg[fld.acx_sel][ACC_W-1]}}, acc_reg[fld.acx_sel][ACC_W-1:SHIFT_N]})
        else $error("lower shift lost sign fill");

    a_dec_reject: assert property (
        (take && !opc_ok)
        |-> !exec ##1 decode_reject)
        else $error("unknown opcode not rejected");

    a_mmr_pulse: assert property (
        (take && opc_ok && !pair_active && ymem_in_mmr)
        |=> mmr_reject && !exec_done)
        else $error("mapped register refusal missing");

    a_ptr_step_down: assert property (
        (exec && fld.cmode == CM_DEC)
        |=> cdp_reg == $past(cdp_reg) - CDP_STEP)
        else $error("pointer did not step down by two");

    a_ptr_hold: assert property (
        (exec && fld.cmode[1] == fld.cmode[0])
        |=> $stable(cdp_reg))
        else $error("pointer moved without a step mode");

    a_upper_flag: assert property (
        (exec && hi_ovf)
        |=> ovf_flags[acy_q])
        else $error("upper overflow flag not set");

    a_flags_clear: assert property (
        (!exec && &ovf_clear)
        |=> ovf_flags == '0)
        else $error("overflow flags not cleared");

    a_sat_narrow: assert property (
        (exec && hi_ovf && mode.accumulator_saturation_bit && !wide)
        |-> hi_res == SAT32_POS || hi_res == SAT32_NEG)
        else $error("32-bit saturation value wrong");

    a_round_low: assert property (
        (exec && fld.rnd && !lo_ovf && !hi_ovf)
        |-> lo_res[15:0] == 16'h0000 && hi_res[15:0] == 16'h0000)
        else $error("rounded result keeps low bits");

    a_frac_lsb: assert property (
        (exec && mode.fractional_mode_bit && !mode.multiply_saturation_mode_bit && !fld.rnd && !lo_ovf)
        |-> lo_res[0] == acc_reg[fld.acx_sel][SHIFT_N])
        else $error("fractional product not doubled");

    a_exec_pulse: assert property (
        !$past(rst)
        |-> exec_done == $past(exec))
        else $error("completion pulse out of step");

    a_pair_no_write: assert property (
        (take && pair_active && !acc_wr_en && !cptr_load)
        |=> $stable(acc_reg) && $stable(cdp_reg))
        else $error("refused pair changed state");

    a_upper_shift_both: assert property (
        (exec && fld.both_shift && !fld.rnd && ymem_hi_data == 16'h0000)
        |-> hi_res == {{SHIFT_N{acc_reg[fld.acy_sel][ACC_W-1]}}, acc_reg[fld.acy_sel][ACC_W-1:SHIFT_N]})
        else $error("upper accumulator not shifted in second variant");
endmodule // dmh_dual_mac

// *** testbench/dmh_coef_mem.sv ***
// coefficient memory model behind the two coefficient data buses
`timescale 1ns/1ps
module dmh_coef_mem import dmh_pkg::*; (
    input wire logic clk, // clock
    input wire logic coef_rd_en, // coefficient read this cycle
    input wire logic [ADDR_W-1:0] coef_hi_addr, // upper coefficient address
    input wire logic [ADDR_W-1:0] coef_lo_addr, // lower coefficient address
    output logic [DATA_W-1:0] second_coefficient_data_bus, // upper coefficient
    output logic [DATA_W-1:0] first_coefficient_data_bus // lower coefficient
);
    logic [DATA_W-1:0] junk = 16'h3c5a;

    // an idle bus toggles every cycle so a stale word can never pass for a read
    always @(posedge clk) begin
        junk <= ~junk;
    end

    // all coefficients sit in internal memory: every address answers at once
    always_comb begin
        second_coefficient_data_bus = coef_rd_en ? {coef_hi_addr[7:0], coef_hi_addr[15:8]} : junk;
        first_coefficient_data_bus = coef_rd_en ? {coef_lo_addr[7:0], coef_lo_addr[15:8]} : junk;
    end
endmodule // dmh_coef_mem

// *** testbench/test_dual_mac_hilo_coeff_datapath.sv ***
// self-checking bench for the dual multiply-accumulate datapath
`timescale 1ns/1ps
module test_dual_mac_hilo_coeff_datapath import dmh_pkg::*; ();
    logic clk = 0, rst = 1, issue_valid = 0, pair_active = 0, cptr_load = 0, acc_wr_en = 0;
    logic issue_ready, coef_rd_en, busy, exec_done, decode_reject, pair_reject, mmr_reject;
    logic [31:0] slot1_word = '0;
    logic [7:0] slot2_byte = '0, rpt_count = '0;
    logic [15:0] xmem_addr = 16'h0010, ymem_addr = 16'h0300, xmem_lo_data = '0, ymem_hi_data = '0;
    logic [15:0] cptr_load_value = '0, coef_hi_addr, coef_lo_addr, coefficient_pointer, ep = '0;
    logic [15:0] second_coefficient_data_bus, first_coefficient_data_bus;
    dmh_mode_t mode = '0;
    logic [1:0] acc_wr_sel = '0;
    logic [39:0] acc_wr_data = '0;
    logic [3:0] ovf_clear = '0, ovf_flags, ef = '0;
    logic [3:0][39:0] acc_q, ex = '0;
    int miscompares = 0, n_compared = 0;

    always #25 clk = ~clk;

    dmh_dual_mac #(.RPT_W(8)) i_dmh_dual_mac (.clk, .rst, .issue_valid, .issue_ready, .slot1_word, .slot2_byte,
        .pair_active, .rpt_count, .xmem_addr, .ymem_addr, .xmem_lo_data, .ymem_hi_data, .coef_rd_en, .coef_hi_addr,
        .coef_lo_addr, .second_coefficient_data_bus, .first_coefficient_data_bus, .mode, .cptr_load,
        .cptr_load_value, .acc_wr_en, .acc_wr_sel, .acc_wr_data, .ovf_clear, .acc_q, .ovf_flags,
        .coefficient_pointer, .busy, .exec_done, .decode_reject, .pair_reject, .mmr_reject);
    dmh_coef_mem i_dmh_coef_mem (.clk, .coef_rd_en, .coef_hi_addr, .coef_lo_addr, .second_coefficient_data_bus,
        .first_coefficient_data_bus);

    task automatic cmp(logic [39:0] g, e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_all();
        for (int i = 0; i < NUM_ACC; i++) cmp(acc_q[i], ex[i]);
        cmp(ovf_flags, ef);
        cmp(coefficient_pointer, ep);
    endtask

    // reference arithmetic of one unit
    function automatic logic [39:0] mac(logic [15:0] d, c, logic du, cu, w, r, sh, logic [39:0] a, output logic ov);
        logic [16:0] e1, e2;
        logic [33:0] p;
        logic [31:0] q;
        logic [40:0] s;
        logic [39:0] v;
        logic t;
        e1 = du | ~mode.sign_extension_mode_bit ? {1'b0, d} : {d[15], d};
        e2 = cu | ~mode.sign_extension_mode_bit ? {1'b0, c} : {c[15], c};
        p = $signed(e1) * $signed(e2);
        q = mode.fractional_mode_bit ? {p[30:0], 1'b0} : p[31:0];
        if (mode.fractional_mode_bit && mode.multiply_saturation_mode_bit && e1 == MIN17 && e2 == MIN17) q = PROD_SAT;
        v = sh ? {{16{a[39]}}, a[39:16]} : a;
        s = {v[39], v} + {{9{q[31]}}, q};
        t = r && mode.rounding_method_bit && s[15:0] == RND_TIE;
        if (r) s = (s + RND_HALF) & ~41'h000_0000_ffff;
        if (t) s[16] = 1'b0;
        ov = w ? s[40] != s[39] : !(&s[40:31] || !(|s[40:31]));
        mac = s[39:0];
        if (ov && mode.accumulator_saturation_bit) mac = w ? (s[40] ? SAT40_NEG : SAT40_POS) : (s[40] ? SAT32_NEG : SAT32_POS);
    endfunction

    task automatic exec(logic [1:0] vr, cm, logic [7:0] s2, logic [15:0] x, y, ya, logic pa, logic [7:0] n);
        logic ok, vk, o1, o2, w;
        logic [39:0] lo, hi;
        @(posedge clk);
        #1;
        for (int t = 0; issue_ready !== 1'b1; t++) begin
            if (t == 20) begin
                miscompares++;
                finish_test();
            end
            @(posedge clk);
            #1;
        end
        slot1_word = {OPC_BYTE0, 20'h0, vr, cm};
        slot2_byte = s2;
        xmem_lo_data = x;
        ymem_hi_data = y;
        ymem_addr = ya;
        pair_active = pa;
        rpt_count = n;
        issue_valid = 1;
        vk = vr == VAR_ACX_SHIFT || vr == VAR_BOTH_SHIFT;
        ok = vk && !pa && ya >= MMR_TOP;
        w = mode.wide_overflow_mode_bit | s2[G40_BIT];
        for (int i = 0; i <= n; i++) begin
            #1;
            if (ok) begin
                cmp(coef_hi_addr, ep);
                cmp(coef_lo_addr, ep[0] ? ep - PARTNER_STEP : ep + PARTNER_STEP);
                lo = mac(x, first_coefficient_data_bus, s2[7], s2[6], w, s2[0], 1'b1, ex[s2[5:4]], o1);
                hi = mac(y, second_coefficient_data_bus, s2[7], s2[6], w, s2[0], vr == VAR_BOTH_SHIFT, ex[s2[3:2]], o2);
                ex[s2[5:4]] = lo;
                ex[s2[3:2]] = hi;
                ef[s2[5:4]] = ef[s2[5:4]] | o1;
                ef[s2[3:2]] = ef[s2[3:2]] | o2;
                ep = cm == CM_INC ? ep + CDP_STEP : cm == CM_DEC ? ep - CDP_STEP : ep;
            end
            @(posedge clk);
            #1;
            issue_valid = 0;
            pair_active = 0;
            cmp(exec_done, ok);
            cmp(busy, ok && i < n);
            cmp(decode_reject, !vk);
            cmp(pair_reject, vk && pa);
            cmp(mmr_reject, vk && !pa && ya < MMR_TOP);
            check_all();
        end
    endtask

    task automatic wr_acc(logic [1:0] s, logic [39:0] d);
        @(posedge clk);
        #1;
        acc_wr_en = 1;
        acc_wr_sel = s;
        acc_wr_data = d;
        ex[s] = d;
        @(posedge clk);
        #1;
        acc_wr_en = 0;
    endtask

    task automatic ld_ptr(logic [15:0] v);
        @(posedge clk);
        #1;
        cptr_load = 1;
        cptr_load_value = v;
        ep = v;
        @(posedge clk);
        #1;
        cptr_load = 0;
    endtask

    task automatic clr(logic [3:0] m);
        @(posedge clk);
        #1;
        ovf_clear = m;
        ef = ef & ~m;
        @(posedge clk);
        #1;
        ovf_clear = '0;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 0;
        cmp(issue_ready, 1'b1);
        check_all();
        // signed lower-only shift from a negative accumulator, lower data in mapped space
        mode = 6'b100001;
        ld_ptr(16'h3710);
        wr_acc(2'h0, 40'hf1_2345_6789);
        wr_acc(2'h1, 40'h00_0001_0000);
        exec(VAR_ACX_SHIFT, CM_INC, 8'h04, 16'h8001, 16'h1234, 16'h0300, 1'b0, 8'h0);
        // both shift, fractional, unsigned operands, pointer stepping down
        mode = 6'b110001;
        wr_acc(2'h2, 40'h80_0000_0000);
        wr_acc(2'h3, 40'h12_3456_789a);
        exec(VAR_BOTH_SHIFT, CM_DEC, 8'hec, 16'hfedc, 16'h8765, 16'h0300, 1'b0, 8'h0);
        // odd pointer, zero extension by mode, local 40-bit with rounding
        mode = 6'b000000;
        ld_ptr(16'h2a91);
        exec(VAR_ACX_SHIFT, 2'h3, 8'h1b, 16'hc000, 16'h9abc, 16'h0300, 1'b0, 8'h0);
        // smallest times smallest in fractional mode, with and without product clamp
        ld_ptr(16'h0080);
        for (int m = 0; m < 2; m++) begin
            mode = m ? 6'b111001 : 6'b110001;
            exec(VAR_BOTH_SHIFT, CM_NONE, 8'h0c, 16'h8000, 16'h8000, 16'h0300, 1'b0, 8'h0);
        end
        // 32-bit overflow saturates, 40-bit option does not, no clamp when disabled
        ld_ptr(16'h3710);
        for (int k = 0; k < 3; k++) begin
            mode = k == 2 ? 6'b100000 : 6'b100001;
            wr_acc(2'h2, 40'h00_7fff_0000);
            exec(VAR_ACX_SHIFT, CM_NONE, k == 1 ? 8'h0a : 8'h08, 16'h0000, 16'h7fff, 16'h0300, 1'b0, 8'h0);
        end
        clr(4'hf);
        check_all();
        // rounding tie under both methods
        ld_ptr(16'h0080);
        for (int r = 0; r < 2; r++) begin
            mode = r ? 6'b000010 : 6'b000000;
            wr_acc(2'h1, 40'h00_0000_0000);
            exec(VAR_ACX_SHIFT, CM_NONE, 8'hc5, 16'h0000, 16'h0001, 16'h0300, 1'b0, 8'h0);
        end
        // zero data in all four variant codes, two refused; then pairing and mapped space
        for (int v = 0; v < 4; v++) exec(2'(v), CM_INC, 8'h04, 16'h0000, 16'h0000, 16'h0300, 1'b0, 8'h0);
        exec(VAR_ACX_SHIFT, CM_INC, 8'h04, 16'h1111, 16'h2222, 16'h0300, 1'b1, 8'h0);
        exec(VAR_ACX_SHIFT, CM_INC, 8'h04, 16'h1111, 16'h2222, 16'h005f, 1'b0, 8'h0);
        // repeated execution, three passes back to back with the pointer climbing
        mode = 6'b100001;
        exec(VAR_BOTH_SHIFT, CM_INC, 8'h04, 16'h0102, 16'hf00d, 16'h0300, 1'b0, 8'h2);
        cmp(issue_ready, 1'b1);
        finish_test();
    end
endmodule // test_dual_mac_hilo_coeff_datapath
